/* File: remote_word_validation_decoder_tb.sv */
// self-checking bench: encoder model drives the line, a queue model predicts results
// assumes the decoder built with short timer counts so a run stays brief
`timescale 1ns/100ps
module remote_word_validation_decoder_tb;
   import rwv_pkg::*;
   logic mclk_in = 1'h0;
   logic rst_b_in = 1'h0;
   logic [9:0] la = 10'h000;
   logic ready = 1'h0;
   logic stall = 1'h0;
   logic din, flag, wvalid;
   logic [3:0] dout, wdata;
   logic [31:0] seed = 32'h66DD;
   logic [31:0] rnd, rnd2;
   logic [17:0] w, w2;
   logic e_flag = 1'h0;
   logic e_st = 1'h0;
   logic [3:0] e_lat = 4'h0;
   logic [3:0] e_first = 4'h0;
   logic [3:0] exp_q[$];
   int n_fail = 0;
   int tests_run = 0;

   always #2 mclk_in = ~mclk_in;

   rwv_enc_model enc (.mclk_in(mclk_in), .din_out(din));

   rwv_decoder #(.DECIDE_CNT(20), .EOW_CNT(100), .EOT_CNT(300)) dut (
      .mclk_in(mclk_in), .rst_b_in(rst_b_in), .din_in(din),
      .local_address_inputs_in(la), .valid_transmission_flag_out(flag),
      .decoded_data_outputs_out(dout), .word_valid_out(wvalid),
      .word_data_out(wdata), .word_ready_in(ready));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // consumer: random ready, or a full stall while the buffer is filled
   always @(posedge mclk_in) begin
      #1;
      rnd2 = xs();
      ready = !stall && rnd2[2];
   end

   // every accepted nibble must be the next one the model pushed
   always @(posedge mclk_in) begin
      if (rst_b_in === 1'h1 && wvalid === 1'h1 && ready === 1'h1) begin
         if (exp_q.size() == 0) check(8'h1, 8'h0);
         else check(wdata, exp_q.pop_front());
      end
   end

   // data digit j is a zero when its nibble bit is clear, else an open when its open bit is set, or a one
   function automatic logic [17:0] mk(input logic [9:0] a, input logic [3:0] nib,
                                      input logic [3:0] opn);
      logic [17:0] r;
      r = {8'h00, a};
      for (int j = 0; j < 4; j++) r[10+2*j +: 2] = nib[j] ? (opn[j] ? 2'h2 : 2'h1) : 2'h0;
      return r;
   endfunction

   // model runs before the word so the queue is ahead of the design's push
   task automatic run_word(input logic [17:0] wd);
      logic bad;
      logic aok;
      logic [3:0] nib;
      bad = 1'h0;
      aok = 1'h1;
      nib = 4'h0;
      for (int k = 0; k < 9; k++) begin
         if (wd[2*k +: 2] == 2'h3) bad = 1'h1;
         if (k < 5) aok = aok && (wd[2*k +: 2] == la[2*k +: 2]);
         else nib[k-5] = (wd[2*k +: 2] != 2'h0);
      end
      if (bad || !aok) begin
         e_flag = 1'h0;
         e_st = 1'h0;
      end else if (e_st && nib == e_first) begin
         if (exp_q.size() < 2) begin
            e_flag = 1'h1;
            e_lat = nib;
            exp_q.push_back(nib);
         end
      end else begin
         e_flag = 1'h0;
         e_st = 1'h1;
         e_first = nib;
      end
      enc.send_word(wd);
      // look just after the edge, the same step the stimulus uses
      #1;
      check(flag, e_flag);
      check(dout, e_lat);
   endtask

   // silence: flag holds past the word gap, then drops at end of transmission
   task automatic end_seq();
      repeat (100) @(posedge mclk_in);
      #1;
      check(flag, e_flag);
      repeat (60) @(posedge mclk_in);
      #1;
      e_flag = 1'h0;
      e_st = 1'h0;
      check(flag, 1'h0);
   endtask

   task automatic do_reset();
      rst_b_in = 1'h0;
      repeat (6) @(posedge mclk_in);
      #1;
      e_flag = 1'h0;
      e_st = 1'h0;
      e_lat = 4'h0;
      exp_q.delete();
      check({flag, wvalid, dout}, 8'h00);
      rst_b_in = 1'h1;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      do_reset();
      for (int i = 0; i < 16; i++) begin
         enc.short_h = (i < 8) ? 6 : 15;
         enc.long_h = (i < 8) ? 34 : 25;
         rnd = xs();
         for (int k = 0; k < 5; k++) la[2*k +: 2] = 2'(rnd[8+3*k +: 3] % 3);
         w = mk(la, 4'(i), rnd[3:0]);
         run_word(w);
         run_word(w);
         end_seq();
      end
      $display("test matching pairs done");
      w2 = w;
      w2[1:0] = (w[1:0] == 2'h2) ? 2'h0 : w[1:0] + 2'h1;
      run_word(w);
      run_word(w);
      run_word(w2);
      run_word(w);
      run_word(w);
      end_seq();
      $display("test address mismatch done");
      w = mk(la, 4'h5, 4'h0);
      w2 = mk(la, 4'hA, 4'h0);
      run_word(w);
      run_word(w2);
      run_word(w2);
      w2[15:14] = 2'h3;
      run_word(w2);
      end_seq();
      $display("test data and pattern mismatch done");
      stall = 1'h1;
      repeat (4) run_word(w);
      end_seq();
      stall = 1'h0;
      repeat (40) @(posedge mclk_in);
      #1;
      check(8'(exp_q.size()), 8'h00);
      check(wvalid, 1'h0);
      $display("test buffer full done");
      run_word(w);
      run_word(w);
      do_reset();
      run_word(w);
      run_word(w);
      end_seq();
      $display("test mid-run reset done");
      final_report();
   end

   initial begin
      repeat (100000) @(posedge mclk_in);
      n_fail++;
      final_report();
   end
endmodule

/* File: rwv_decoder.sv */
// receive side of the single-wire remote word link: pulse timing, word framing,
// two-word validation, output latch and a buffered stream of accepted nibbles
// assumes din_in is asynchronous; the paired encoder sends two words per sequence
`timescale 1ns/100ps

// What this block does
// - flag needs both addresses equal local address
// - flag needs both data nibbles identical
// - flag stays until mismatch or long silence
// - pulse timer decides bit at one-third point
// - gap timer restarted while pulses arrive
// - end of word at gap two-thirds point
// - end of transmission at gap one-third point
// - decision instant kept away from pulse edges
// - five address digits, then four stored data bits
// - open data digit decodes as one
// - matching nibbles go to held output latch if stream buffer has room
module rwv_decoder
   import rwv_pkg::*;
#(
   parameter int DECIDE_CNT = DECIDE_CYCLES,
   parameter int EOW_CNT = EOW_CYCLES,
   parameter int EOT_CNT = EOT_CYCLES
) (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic din_in,
   input wire logic [2*ADDR_DIGITS-1:0] local_address_inputs_in,
   output logic valid_transmission_flag_out,
   output logic [DATA_BITS-1:0] decoded_data_outputs_out,
   output logic word_valid_out,
   output logic [DATA_BITS-1:0] word_data_out,
   input wire logic word_ready_in
);
   localparam logic [PW_CNT_W-1:0] DECIDE_LAST = PW_CNT_W'(DECIDE_CNT - 1);
   localparam logic [GAP_CNT_W-1:0] EOW_LAST = GAP_CNT_W'(EOW_CNT - 1);
   localparam logic [GAP_CNT_W-1:0] EOT_LAST = GAP_CNT_W'(EOT_CNT - 1);
   localparam logic [GAP_CNT_W-1:0] GAP_HOLD = GAP_CNT_W'(EOT_CNT);
   localparam logic [PCNT_W-1:0] PULSE_FULL = PCNT_W'(PULSES_PER_WORD);

   logic din_meta_reg;
   logic din_sync_reg;
   logic din_prev_reg;
   logic [2*ADDR_DIGITS-1:0] addr_meta_reg;
   logic [2*ADDR_DIGITS-1:0] addr_sync_reg;
   logic pw_run_reg;
   logic [PW_CNT_W-1:0] pw_cnt_reg;
   logic [GAP_CNT_W-1:0] gap_cnt_reg;
   logic [PULSES_PER_WORD-1:0] pulses_reg;
   logic [PCNT_W-1:0] pulse_cnt_reg;
   logic [DATA_BITS-1:0] stored_reg;
   rwv_state_e state_reg;
   rwv_word_s rx_word;
   logic din_rise;
   logic bit_decision_instant;
   logic end_of_word_event;
   logic end_of_transmission_event;
   logic pair_ok;
   logic push;
   logic buf_ready;

   // ------------------------------------------------------------
   // input synchroniser and edge
   // ------------------------------------------------------------
   // two flops before any logic sees the serial pin or the address switches
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         din_meta_reg <= 1'b0;
         din_sync_reg <= 1'b0;
         din_prev_reg <= 1'b0;
         addr_meta_reg <= '0;
         addr_sync_reg <= '0;
      end else begin
         din_meta_reg <= din_in;
         din_sync_reg <= din_meta_reg;
         din_prev_reg <= din_sync_reg;
         addr_meta_reg <= local_address_inputs_in;
         addr_sync_reg <= addr_meta_reg;
      end
   end
   assign din_rise = din_sync_reg && !din_prev_reg;

   // ------------------------------------------------------------
   // pulse-width timer
   // ------------------------------------------------------------
   // decide at one third
   // each rising edge restarts the timer; at the decision point a still-high
   // input means a long pulse, a low input a short one
   assign bit_decision_instant = pw_run_reg && (pw_cnt_reg == DECIDE_LAST);

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         pw_run_reg <= 1'b0;
         pw_cnt_reg <= '0;
      end else if (din_rise) begin
         pw_run_reg <= 1'b1;
         pw_cnt_reg <= '0;
      end else if (bit_decision_instant) begin
         pw_run_reg <= 1'b0;
      end else if (pw_run_reg) begin
         pw_cnt_reg <= pw_cnt_reg + PW_CNT_W'(1);
      end
   end

   // ------------------------------------------------------------
   // word-gap timer
   // ------------------------------------------------------------
   // restart on signal
   // saturates one past the end-of-transmission point so each event fires once
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         gap_cnt_reg <= '0;
      end else if (din_sync_reg) begin
         gap_cnt_reg <= '0;
      end else if (gap_cnt_reg != GAP_HOLD) begin
         gap_cnt_reg <= gap_cnt_reg + GAP_CNT_W'(1);
      end
   end

   assign end_of_word_event = !din_sync_reg && (gap_cnt_reg == EOW_LAST);
   assign end_of_transmission_event = !din_sync_reg && (gap_cnt_reg == EOT_LAST) &&
                                      (gap_cnt_reg != EOW_LAST);

   // ------------------------------------------------------------
   // pulse collection
   // ------------------------------------------------------------
   // sample at decision only
   // pulse count saturates one past a full word so extra pulses flag an error
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         pulses_reg <= '0;
         pulse_cnt_reg <= '0;
      end else if (end_of_word_event || end_of_transmission_event) begin
         pulse_cnt_reg <= '0;
      end else if (bit_decision_instant) begin
         pulses_reg <= {pulses_reg[PULSES_PER_WORD-2:0], din_sync_reg};
         if (pulse_cnt_reg <= PULSE_FULL) begin
            pulse_cnt_reg <= pulse_cnt_reg + PCNT_W'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // word decode
   // ------------------------------------------------------------
   // first pulse of digit k sits at bit 17-2k, second at 16-2k
   always_comb begin
      logic first;
      logic second;
      rwv_digit_e dig;
      first = 1'b0;
      second = 1'b0;
      dig = DIG_ZERO;
      rx_word.ok = (pulse_cnt_reg == PULSE_FULL);
      rx_word.addr_ok = 1'b1;
      rx_word.data = '0;
      for (int k = 0; k < WORD_DIGITS; k++) begin
         first = pulses_reg[PULSES_PER_WORD-1-2*k];
         second = pulses_reg[PULSES_PER_WORD-2-2*k];
         // long then short is open; short then long marks the word not ok
         dig = first ? (second ? DIG_ONE : DIG_OPEN) : DIG_ZERO;
         if (!first && second) begin
            rx_word.ok = 1'b0;
         end
         if (k < ADDR_DIGITS) begin
            if (dig != rwv_digit_e'(addr_sync_reg[2*k +: 2])) begin
               rx_word.addr_ok = 1'b0;
            end
         end else begin
            rx_word.data[k-ADDR_DIGITS] = first;
         end
      end
   end

   // ------------------------------------------------------------
   // validation state and output latch
   // ------------------------------------------------------------
   // nibble pair compare
   assign pair_ok = rx_word.ok && rx_word.addr_ok && (rx_word.data == stored_reg);
   // a full stream buffer holds back the pair; the stored nibble is kept
   assign push = end_of_word_event && pair_ok && (state_reg != ST_IDLE);

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         state_reg <= ST_IDLE;
         valid_transmission_flag_out <= VT_RST;
         stored_reg <= DATA_RST;
      end else if (end_of_transmission_event) begin
         state_reg <= ST_IDLE;
         valid_transmission_flag_out <= 1'b0;
      end else if (end_of_word_event) begin
         if (!(rx_word.ok && rx_word.addr_ok)) begin
            state_reg <= ST_IDLE;
            valid_transmission_flag_out <= 1'b0;
         end else if (state_reg == ST_IDLE || !pair_ok) begin
            state_reg <= ST_FIRST;
            stored_reg <= rx_word.data;
            valid_transmission_flag_out <= (state_reg == ST_IDLE) &&
                                           valid_transmission_flag_out;
         end else if (buf_ready) begin
            state_reg <= ST_PAIRED;
            valid_transmission_flag_out <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         decoded_data_outputs_out <= DATA_RST;
      end else if (push && buf_ready) begin
         decoded_data_outputs_out <= rx_word.data;
      end
   end

   // ------------------------------------------------------------
   // stream buffer
   // ------------------------------------------------------------
   rwv_skid_buf #(
      .WIDTH(DATA_BITS)
   ) u_buf (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .in_valid_in(push),
      .in_data_in(rx_word.data),
      .in_ready_out(buf_ready),
      .out_valid_out(word_valid_out),
      .out_data_out(word_data_out),
      .out_ready_in(word_ready_in)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);

   a_vt_addr_match: assert property ($rose(valid_transmission_flag_out) |->
      $past(end_of_word_event) && $past(rx_word.addr_ok) && $past(state_reg) != ST_IDLE)
      else $error("flag rose without two matching addresses");
   a_vt_data_pair: assert property ($rose(valid_transmission_flag_out) |->
      $past(rx_word.data) == $past(stored_reg) && decoded_data_outputs_out == $past(rx_word.data))
      else $error("flag rose without equal nibbles");
   a_vt_drop_cause: assert property ($fell(valid_transmission_flag_out) |->
      $past(end_of_transmission_event) || ($past(end_of_word_event) && !$past(pair_ok)))
      else $error("flag fell without mismatch or silence");
   a_pulse_decide: assert property (bit_decision_instant |=>
      pulses_reg[0] == $past(din_sync_reg) && !pw_run_reg && pw_cnt_reg == DECIDE_LAST)
      else $error("bit not taken at decision point");
   a_gap_restart: assert property (din_sync_reg |=> gap_cnt_reg == '0 &&
      !end_of_word_event)
      else $error("gap timer not restarted by signal");
   a_eow_once: assert property (end_of_word_event |=> !end_of_word_event [*2]
      ##0 pulse_cnt_reg == '0)
      else $error("end of word repeated or count kept");
   a_eot_clears: assert property (end_of_transmission_event |=>
      state_reg == ST_IDLE && !valid_transmission_flag_out)
      else $error("end of transmission left state");
   a_first_store: assert property (end_of_word_event && rx_word.ok &&
      rx_word.addr_ok && state_reg == ST_IDLE |=> state_reg == ST_FIRST &&
      stored_reg == $past(rx_word.data) && $stable(decoded_data_outputs_out))
      else $error("first word not stored correctly");
   a_latch_hold: assert property (!(push && buf_ready) |=>
      $stable(decoded_data_outputs_out))
      else $error("data latch changed without valid pair");
   a_reset_clean: assert property (@(posedge mclk_in) disable iff (1'b0)
      !rst_b_in |=> !valid_transmission_flag_out && decoded_data_outputs_out == DATA_RST &&
      state_reg == ST_IDLE && stored_reg == DATA_RST)
      else $error("reset left state behind");

   c_vt_rise: cover property ($rose(valid_transmission_flag_out));
   c_vt_eot: cover property (valid_transmission_flag_out && end_of_transmission_event);
   c_buf_full: cover property (push && !buf_ready);
   c_mismatch: cover property (end_of_word_event && rx_word.ok && !rx_word.addr_ok);
endmodule

/* File: rwv_enc_model.sv */
// behavioural model of the paired encoder that drives the serial line
// assumes one caller at a time; the line idles low between words and frames
`timescale 1ns/100ps
module rwv_enc_model (
   input wire logic mclk_in,
   output logic din_out
);
   int short_h = 10;
   int long_h = 30;
   int bit_per = 40;
   int gap_len = 150;

   initial din_out = 1'h0;

   // edges away from decision
   // one pulse, high for hi cycles, low for the rest of the bit period
   task automatic pulse(input int hi);
      @(posedge mclk_in);
      #1 din_out = 1'h1;
      repeat (hi) @(posedge mclk_in);
      #1 din_out = 1'h0;
      repeat (bit_per - hi - 1) @(posedge mclk_in);
   endtask

   // digit pulse pairs
   // code 3 sends short then long, a pattern that exists only to be refused
   task automatic send_word(input logic [17:0] w);
      for (int k = 0; k < 9; k++) begin
         case (w[2*k +: 2])
            2'h0: begin pulse(short_h); pulse(short_h); end
            2'h1: begin pulse(long_h); pulse(long_h); end
            2'h2: begin pulse(long_h); pulse(short_h); end
            default: begin pulse(short_h); pulse(long_h); end
         endcase
      end
      repeat (gap_len) @(posedge mclk_in);
   endtask
endmodule

/* File: rwv_pkg.sv */
// package for the remote word validation decoder: timing, widths, codes, carriers
// assumes a 250 MHz sampling clock and an encoder clock given as a period in ns
package rwv_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_NS = 4;
   localparam int ENC_CLK_PERIOD_NS = 10000;
   localparam int ENC_CLK_CYCLES = ENC_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
   // decay points in thousandths of an encoder period (rc decay to 1/3, 2/3, 1/3)
   localparam int DECIDE_PERIODS_K = 1890;
   localparam int EOW_PERIODS_K = 13580;
   localparam int EOT_PERIODS_K = 36803;
   localparam int DECIDE_CYCLES = ENC_CLK_CYCLES * DECIDE_PERIODS_K / 1000;
   localparam int EOW_CYCLES = ENC_CLK_CYCLES * EOW_PERIODS_K / 1000;
   localparam int EOT_CYCLES = ENC_CLK_CYCLES * EOT_PERIODS_K / 1000;
   localparam int PW_CNT_W = 16;
   localparam int GAP_CNT_W = 17;

   // ------------------------------------------------------------
   // word layout
   // ------------------------------------------------------------
   localparam int ADDR_DIGITS = 5;
   localparam int DATA_BITS = 4;
   localparam int WORD_DIGITS = 9;
   localparam int PULSES_PER_WORD = 2 * WORD_DIGITS;
   localparam int PCNT_W = 5;
   localparam logic VT_RST = 1'h0;
   localparam logic [DATA_BITS-1:0] DATA_RST = 4'h0;

   // trinary digit code, also used for the local address inputs
   typedef enum logic [1:0] {
      DIG_ZERO = 2'h0,
      DIG_ONE = 2'h1,
      DIG_OPEN = 2'h2
   } rwv_digit_e;

   // matching progress, gray along idle -> first -> paired
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_FIRST = 2'h1,
      ST_PAIRED = 2'h3
   } rwv_state_e;

   // one decoded word
   typedef struct packed {
      logic ok;
      logic addr_ok;
      logic [DATA_BITS-1:0] data;
   } rwv_word_s;

endpackage

/* File: rwv_skid_buf.sv */
// two-entry buffer with valid/ready on both sides, all outputs from flops
// assumes producer and consumer share the clock and reset
`timescale 1ns/100ps
module rwv_skid_buf #(
   parameter int WIDTH = 4
) (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   logic skid_valid_reg;
   logic [WIDTH-1:0] skid_data_reg;
   logic head_free;

   assign head_free = !out_valid_out || out_ready_in;

   // head entry: refill from skid first so order is kept
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         out_valid_out <= 1'b0;
         out_data_out <= '0;
      end else if (head_free) begin
         out_valid_out <= skid_valid_reg || (in_valid_in && in_ready_out);
         out_data_out <= skid_valid_reg ? skid_data_reg : in_data_in;
      end
   end

   // skid entry catches a word taken while the head is stalled
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         skid_valid_reg <= 1'b0;
         skid_data_reg <= '0;
      end else if (head_free) begin
         skid_valid_reg <= 1'b0;
      end else if (in_valid_in && in_ready_out) begin
         skid_valid_reg <= 1'b1;
         skid_data_reg <= in_data_in;
      end
   end

   // registered ready: full only when both entries hold words
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         in_ready_out <= 1'b0;
      end else begin
         in_ready_out <= !(out_valid_out && !out_ready_in &&
                           (skid_valid_reg || (in_valid_in && in_ready_out)));
      end
   end
endmodule
